// ---- verilog/dsio_sram_port.sv ----
// Device-side logic of a separate-I/O double-data-rate SRAM with a burst of two.
// Assumes all pins, link clocks included, are sampled by clock at 200 MHz,
// and that pll_disable_n and single_clock are static straps during traffic.
`timescale 1ns/100ps

module dsio_sram_port #(
    parameter int WORD_W = dsio_pkg::WORD_W_X18,
    parameter int ADDR_W = dsio_pkg::ADDR_W_X18
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire dsio_pkg::dsio_clk_pins_t clk_pins,
    input wire logic load_strobe_n,
    input wire logic read_select,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [WORD_W-1:0] write_data,
    input wire logic [WORD_W/dsio_pkg::LANE_W-1:0] lane_write_select_n,
    output logic [WORD_W-1:0] read_data,
    output logic read_data_oe,
    output logic echo_clock,
    output logic echo_clock_n
);
    import dsio_pkg::*;

    localparam int LANES = WORD_W / LANE_W;
    localparam int BUS_W = 2 + ADDR_W + WORD_W + LANES;
    localparam int DEPTH = 2 ** ADDR_W;

    generate
        if (!((WORD_W == WORD_W_X18 && ADDR_W == ADDR_W_X18) ||
              (WORD_W == WORD_W_X36 && ADDR_W == ADDR_W_X36)))
        begin : g_bad_geometry
            $error("dsio_sram_port: geometry must be 2M x 18 or 1M x 36");
        end
    endgenerate

    // Merge a new word into an old one lane by lane
    function automatic logic [WORD_W-1:0] lane_merge(
        input logic [WORD_W-1:0] old_word,
        input logic [WORD_W-1:0] new_word,
        input logic [LANES-1:0] sel_n
    );
        logic [WORD_W-1:0] merged;
        merged = old_word;
        for (int i = 0; i < LANES; i++)
        begin
            // Deselected lane keeps its stored bits
            if (!sel_n[i])
            begin
                merged[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
            end
        end
        return merged;
    endfunction : lane_merge

    // Clock pin synchroniser stages
    dsio_clk_pins_t clk_s1;
    dsio_clk_pins_t clk_s2;
    dsio_clk_pins_t clk_s3;
    // Filtered clock and strap levels
    dsio_clk_pins_t clk_lvl;
    // Level that the filter takes at the coming edge
    dsio_clk_pins_t next_lvl;
    // One-cycle rise events of each filtered pin
    logic [CLK_PINS_W-1:0] rise_vec;
    dsio_clk_pins_t rise;

    // Data pin stages, delayed alongside the clocks
    logic [BUS_W-1:0] bus_s1;
    logic [BUS_W-1:0] bus_s2;
    logic [BUS_W-1:0] bus_s3;

    // Unpacked view of the aligned data pins
    logic cmd_load_n;
    logic cmd_read;
    logic [ADDR_W-1:0] cmd_addr;
    logic [WORD_W-1:0] cmd_wdata;
    logic [LANES-1:0] cmd_lane_n;

    // Selected launching clock events
    logic oc_rise;
    logic ocn_rise;
    // High selects the 1.5 cycle latency
    logic lat_half;

    // Write sequencing
    dsio_wstate_t wstate;
    logic [ADDR_W-1:0] wr_addr;
    logic [WORD_W-1:0] wr_word0;
    logic [LANES-1:0] wr_lane0_n;

    // Array storage, word 0 in the low half
    logic [BURST_LEN*WORD_W-1:0] mem [0:DEPTH-1];

    // Read queue between command and launch
    logic q_valid;
    logic [BURST_LEN*WORD_W-1:0] q_buf;
    logic [BURST_LEN*WORD_W-1:0] act_buf;
    logic pend0;
    logic pend1;

    // Decoded command events
    logic take_read;
    logic take_write;

    // Three-stage synchronisers for every pin
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            clk_s1 <= CLK_PINS_RESET;
            clk_s2 <= CLK_PINS_RESET;
            clk_s3 <= CLK_PINS_RESET;
            bus_s1 <= '0;
            bus_s2 <= '0;
            bus_s3 <= '0;
        end
        else
        begin
            clk_s1 <= clk_pins;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            bus_s1 <= {load_strobe_n, read_select, address, write_data, lane_write_select_n};
            bus_s2 <= bus_s1;
            bus_s3 <= bus_s2;
        end
    end

    // Level changes only when stages two and three agree
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            clk_lvl <= CLK_PINS_RESET;
        end
        else
        begin
            clk_lvl <= next_lvl;
        end
    end

    // Shared by the level flops and the echo flops so both move together
    assign next_lvl = (clk_s2 & clk_s3) | (clk_lvl & (clk_s2 | clk_s3));

    // Rise is the agreeing high arriving over a low level
    assign rise_vec = clk_s2 & clk_s3 & ~clk_lvl;
    assign rise = rise_vec;

    // One address, dedicated write inputs
    // Data stage three lines up with the clock edge decision
    assign {cmd_load_n, cmd_read, cmd_addr, cmd_wdata, cmd_lane_n} = bus_s3;

    // Output pair, or input pair in single clock mode
    assign oc_rise = clk_lvl.single_clock ? rise.in_clk : rise.out_clk;
    assign ocn_rise = clk_lvl.single_clock ? rise.in_clk_n : rise.out_clk_n;
    assign lat_half = clk_lvl.pll_disable_n;

    // Commands sampled only on true input clock rises
    assign take_read = rise.in_clk && !cmd_load_n && cmd_read;
    assign take_write = rise.in_clk && !cmd_load_n && !cmd_read;

    // Write sequencer: address on K, word 0 on K_n, word 1 on next K
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            wstate <= W_IDLE;
            wr_addr <= '0;
            wr_word0 <= '0;
            wr_lane0_n <= '1;
        end
        else
        begin
            case (wstate)
                W_IDLE:
                begin
                    // Write address captured on the input clock
                    if (take_write)
                    begin
                        wr_addr <= cmd_addr;
                        wstate <= W_WORD0;
                    end
                end
                W_WORD0:
                begin
                    // First word on the complementary clock
                    if (rise.in_clk_n)
                    begin
                        wr_word0 <= cmd_wdata;
                        wr_lane0_n <= cmd_lane_n;
                        wstate <= W_WORD1;
                    end
                end
                W_WORD1:
                begin
                    // Second word lands now; a new write may follow at once
                    if (rise.in_clk)
                    begin
                        if (take_write)
                        begin
                            wr_addr <= cmd_addr;
                            wstate <= W_WORD0;
                        end
                        else
                        begin
                            wstate <= W_IDLE;
                        end
                    end
                end
                default:
                begin
                    wstate <= W_IDLE;
                end
            endcase
        end
    end

    // Array update; no reset, contents are undefined at power-up
    always_ff @(posedge clock)
    begin
        // Commit both words internally, no strobe timing
        if (wstate == W_WORD1 && rise.in_clk)
        begin
            // Each lane gated by its own select
            mem[wr_addr] <= {lane_merge(mem[wr_addr][BURST_LEN*WORD_W-1:WORD_W], cmd_wdata, cmd_lane_n),
                             lane_merge(mem[wr_addr][WORD_W-1:0], wr_word0, wr_lane0_n)};
        end
    end

    // Read queue; a new read outranks the launch-side clear
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            q_valid <= 1'b0;
            q_buf <= '0;
        end
        else
        begin
            if (oc_rise)
            begin
                q_valid <= 1'b0;
            end
            // Both words of the location fetched together
            if (take_read)
            begin
                q_valid <= 1'b1;
                q_buf <= mem[cmd_addr];
            end
        end
    end

    // Launch sequencer for the two read words
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            read_data <= '0;
            read_data_oe <= RESET_OE;
            act_buf <= '0;
            pend0 <= 1'b0;
            pend1 <= 1'b0;
        end
        else if (oc_rise)
        begin
            if (q_valid)
            begin
                act_buf <= q_buf;
            end
            if (!lat_half)
            begin
                // Word 0 on the true edge one cycle after the address
                if (q_valid)
                begin
                    read_data <= q_buf[WORD_W-1:0];
                    read_data_oe <= 1'b1;
                    pend1 <= 1'b1;
                end
                else
                begin
                    read_data_oe <= 1'b0;
                    pend1 <= 1'b0;
                end
                pend0 <= 1'b0;
            end
            else
            begin
                // True edge carries word 1 of the earlier read
                if (pend1)
                begin
                    read_data <= act_buf[BURST_LEN*WORD_W-1:WORD_W];
                    read_data_oe <= 1'b1;
                end
                else
                begin
                    read_data_oe <= 1'b0;
                end
                pend1 <= 1'b0;
                pend0 <= q_valid;
            end
        end
        else if (ocn_rise)
        begin
            if (!lat_half)
            begin
                // Word 1 half a cycle after word 0
                if (pend1)
                begin
                    read_data <= act_buf[BURST_LEN*WORD_W-1:WORD_W];
                    read_data_oe <= 1'b1;
                end
                else
                begin
                    read_data_oe <= 1'b0;
                end
                pend1 <= 1'b0;
            end
            else
            begin
                // Word 0 on the complementary edge, 1.5 cycles in
                if (pend0)
                begin
                    read_data <= act_buf[WORD_W-1:0];
                    read_data_oe <= 1'b1;
                    pend1 <= 1'b1;
                end
                else
                begin
                    read_data_oe <= 1'b0;
                end
                pend0 <= 1'b0;
            end
        end
    end

    // Echo clocks track the launching pair through one flop
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            echo_clock <= RESET_ECHO;
            echo_clock_n <= RESET_ECHO;
        end
        else
        begin
            // Next filtered level, so the echo edge lands with the data edge
            echo_clock <= clk_lvl.single_clock ? next_lvl.in_clk : next_lvl.out_clk;
            echo_clock_n <= clk_lvl.single_clock ? next_lvl.in_clk_n : next_lvl.out_clk_n;
        end
    end

endmodule : dsio_sram_port

// ---- shared/dsio_pkg.sv ----
// Shared constants and types for the separate-I/O burst-of-two SRAM port.
// Assumes one 200 MHz system clock that samples every pin, link clocks included.
package dsio_pkg;

    // Word and address widths of the two array organisations
    localparam int WORD_W_X18 = 18;
    localparam int ADDR_W_X18 = 20;
    localparam int WORD_W_X36 = 36;
    localparam int ADDR_W_X36 = 19;

    // One byte write select covers one lane of this many bits
    localparam int LANE_W = 9;

    // Words moved per transaction
    localparam int BURST_LEN = 2;

    // Pin synchroniser depth
    localparam int SYNC_STAGES = 3;

    // Reset values
    localparam logic RESET_OE = 1'b0;
    localparam logic RESET_ECHO = 1'b0;

    // Clock and strap pins, filtered together
    typedef struct packed {
        logic in_clk;         // True input clock
        logic in_clk_n;       // Complementary input clock
        logic out_clk;        // True output clock
        logic out_clk_n;      // Complementary output clock
        logic single_clock;   // High when no output clock pair is supplied
        logic pll_disable_n;  // High selects 1.5 cycle read latency
    } dsio_clk_pins_t;

    localparam int CLK_PINS_W = $bits(dsio_clk_pins_t);
    localparam dsio_clk_pins_t CLK_PINS_RESET = '0;

    // Write sequencer states, one-hot
    typedef enum logic [2:0] {
        W_IDLE = 3'h1,
        W_WORD0 = 3'h2,
        W_WORD1 = 3'h4
    } dsio_wstate_t;

endpackage : dsio_pkg

// ---- sim/dsio_sram_port_sva.sv ----
// Pin checks for dsio_sram_port.
// Assumes link clocks far slower than clock.
`timescale 1ns/100ps

module dsio_sram_port_sva #(
    parameter int WORD_W = dsio_pkg::WORD_W_X18,
    parameter int ADDR_W = dsio_pkg::ADDR_W_X18
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire dsio_pkg::dsio_clk_pins_t clk_pins,
    input wire logic load_strobe_n,
    input wire logic read_select,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [WORD_W-1:0] write_data,
    input wire logic [WORD_W/dsio_pkg::LANE_W-1:0] lane_write_select_n,
    input wire logic [WORD_W-1:0] read_data,
    input wire logic read_data_oe,
    input wire logic echo_clock,
    input wire logic echo_clock_n
);
    import dsio_pkg::*;
    // One domain, one reset
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    echo_true_a: assert property ($rose(clk_pins.out_clk) && !clk_pins.single_clock |-> ##[2:6] echo_clock)
        else $error("echo late");
    echo_comp_a: assert property ($rose(clk_pins.out_clk_n) && !clk_pins.single_clock |-> ##[2:6] echo_clock_n)
        else $error("echo_n late");
    echo_single_a: assert property ($rose(clk_pins.in_clk) && clk_pins.single_clock |-> ##[2:6] echo_clock)
        else $error("single echo late");
    data_edge_a: assert property ($changed(read_data) |-> $rose(echo_clock) || $rose(echo_clock_n))
        else $error("data off edge");
    oe_edge_a: assert property ($changed(read_data_oe) |-> $rose(echo_clock) || $rose(echo_clock_n))
        else $error("oe off edge");
    burst_len_a: assert property ($rose(read_data_oe) |-> read_data_oe [*8])
        else $error("burst cut");
    lat_long_a: assert property ($rose(read_data_oe) && clk_pins.pll_disable_n |-> $rose(echo_clock_n))
        else $error("long latency");
    lat_short_a: assert property ($rose(read_data_oe) && !clk_pins.pll_disable_n |-> $rose(echo_clock))
        else $error("short latency");
    read_answer_a: assert property ($rose(clk_pins.in_clk) && !load_strobe_n && read_select
        |-> ##[3:40] read_data_oe) else $error("read lost");
    cover property ($rose(read_data_oe) && clk_pins.pll_disable_n);
    cover property ($rose(read_data_oe) && !clk_pins.pll_disable_n);
    cover property ($rose(echo_clock) && clk_pins.single_clock);
endmodule : dsio_sram_port_sva

bind dsio_sram_port dsio_sram_port_sva #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) u_sva (.clock, .reset_n,
    .clk_pins, .load_strobe_n, .read_select, .address, .write_data, .lane_write_select_n, .read_data,
    .read_data_oe, .echo_clock, .echo_clock_n);

// ---- sim/dsio_ctrl_model.sv ----
// Controller model: link clocks, commands, write words; catches reads.
// Assumes clock at 200 MHz, so one link period is 16 clocks.
`timescale 1ns/100ps

module dsio_ctrl_model #(
    parameter int WORD_W = dsio_pkg::WORD_W_X18,
    parameter int ADDR_W = dsio_pkg::ADDR_W_X18,
    parameter int LN = WORD_W/dsio_pkg::LANE_W
) (
    input wire logic clock,
    input wire logic [WORD_W-1:0] read_data,
    input wire logic read_data_oe,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    output dsio_pkg::dsio_clk_pins_t clk_pins,
    output logic load_strobe_n,
    output logic read_select,
    output logic [ADDR_W-1:0] address,
    output logic [WORD_W-1:0] write_data,
    output logic [LN-1:0] lane_write_select_n
);
    import dsio_pkg::*;
    logic [WORD_W+LN-1:0] w1q = '0; // Word1 and lanes for next K rise
    logic [WORD_W:0] rq[$]; // Reads, top bit set if caught on echo_n
    logic pe = 1'b0;
    logic pen = 1'b0;
    initial
    begin
        clk_pins = CLK_PINS_RESET;
        {load_strobe_n, read_select, address, write_data, lane_write_select_n} = '1;
    end
    // Straps change only while idle
    task automatic mode(input logic pll, input logic single);
        @(posedge clock);
        clk_pins <= {4'h4, single, pll};
        repeat (8) @(posedge clock);
    endtask : mode
    task automatic cyc(input logic ld_n, input logic rsel, input logic [ADDR_W-1:0] a,
        input logic [WORD_W-1:0] w0, input logic [WORD_W-1:0] w1, input logic [LN-1:0] l0, input logic [LN-1:0] l1);
        @(posedge clock);
        {load_strobe_n, read_select, address} <= {ld_n, rsel, a};
        {write_data, lane_write_select_n} <= w1q;
        {clk_pins.out_clk, clk_pins.out_clk_n} <= {1'b0, !clk_pins.single_clock};
        // Released data shows junk, not the old word
        w1q = (ld_n | rsel) ? ~w1q : {w1, l1};
        repeat (4) @(posedge clock);
        {clk_pins.in_clk, clk_pins.in_clk_n} <= 2'h2;
        repeat (4) @(posedge clock);
        {write_data, lane_write_select_n} <= (ld_n | rsel) ? ~{write_data, lane_write_select_n} : {w0, l0};
        {clk_pins.out_clk, clk_pins.out_clk_n} <= {!clk_pins.single_clock, 1'b0};
        repeat (4) @(posedge clock);
        {clk_pins.in_clk, clk_pins.in_clk_n} <= 2'h1;
        repeat (3) @(posedge clock);
    endtask : cyc
    always @(posedge clock)
    begin
        {pe, pen} <= {echo_clock, echo_clock_n};
        if (read_data_oe === 1'b1 && ((echo_clock && !pe) || (echo_clock_n && !pen)))
            rq.push_back({echo_clock_n && !pen, read_data});
    end
endmodule : dsio_ctrl_model

// ---- sim/dsio_sram_port_tb.sv ----
// Bench for dsio_sram_port, x18 organisation.
// Assumes the controller model and the bound checker.
`timescale 1ns/100ps

module dsio_sram_port_tb;
    import dsio_pkg::*;
    typedef struct packed {
        logic [19:0] a;
        logic [17:0] w0, w1, e0, e1;
        logic [1:0] l0, l1;
    } dsio_row_t;
    // Write, then expected read back
    localparam dsio_row_t ROWS [4] = '{
        '{20'h00001, 18'h12345, 18'h2ABCD, 18'h12345, 18'h2ABCD, 2'h0, 2'h0},
        '{20'h00001, 18'h3FFFF, 18'h3FFFF, 18'h3FF45, 18'h2ABFF, 2'h1, 2'h2},
        '{20'hFFFFF, 18'h00000, 18'h3FFFF, 18'h00000, 18'h3FFFF, 2'h0, 2'h0},
        '{20'hFFFFF, 18'h3FFFF, 18'h00000, 18'h00000, 18'h3FFFF, 2'h3, 2'h3}};
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    dsio_clk_pins_t clk_pins;
    logic load_strobe_n, read_select, read_data_oe, echo_clock, echo_clock_n;
    logic [19:0] address;
    logic [17:0] write_data, read_data;
    logic [1:0] lane_write_select_n;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    always #2.5 clock = ~clock;
    dsio_sram_port DUT (.clock, .reset_n, .clk_pins, .load_strobe_n, .read_select, .address, .write_data,
        .lane_write_select_n, .read_data, .read_data_oe, .echo_clock, .echo_clock_n);
    dsio_ctrl_model ctrl (.clock, .read_data, .read_data_oe, .echo_clock, .echo_clock_n, .clk_pins,
        .load_strobe_n, .read_select, .address, .write_data, .lane_write_select_n);
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    // Hang guard, runs need about 700 clocks
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            test_done();
        end
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // Word and its echo edge; empty queue fails
    task automatic cmp_rd(input logic [18:0] exp);
        logic [18:0] got;
        got = ~exp;
        if (ctrl.rq.size() > 0)
            got = ctrl.rq.pop_front();
        cmp("read word", {13'h0, exp}, {13'h0, got});
    endtask : cmp_rd
    task automatic quiet();
        #1;
        cmp("idle outputs", '0, {read_data_oe, echo_clock, echo_clock_n, read_data});
    endtask : quiet
    task automatic idle(input int n);
        repeat (n) ctrl.cyc(1'b1, 1'b0, '0, '0, '0, '1, '1);
    endtask : idle
    task automatic rd(input logic [19:0] a);
        ctrl.cyc(1'b0, 1'b1, a, '0, '0, '1, '1);
        idle(3);
    endtask : rd
    initial
    begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        quiet();
        ctrl.mode(1'b1, 1'b0);
        foreach (ROWS[i])
        begin
            ctrl.cyc(1'b0, 1'b0, ROWS[i].a, ROWS[i].w0, ROWS[i].w1, ROWS[i].l0, ROWS[i].l1);
            idle(1);
            rd(ROWS[i].a);
            cmp_rd({1'b1, ROWS[i].e0});
            cmp_rd({1'b0, ROWS[i].e1});
        end
        $display("table done");
        // Write word1 edge carries a read, then reads back to back
        ctrl.mode(1'b0, 1'b0);
        ctrl.cyc(1'b0, 1'b0, 20'h00002, 18'h0F0F0, 18'h30303, 2'h0, 2'h0);
        ctrl.cyc(1'b0, 1'b1, 20'h00001, '0, '0, '1, '1);
        rd(20'h00002);
        cmp_rd({1'b0, 18'h3FF45});
        cmp_rd({1'b1, 18'h2ABFF});
        cmp_rd({1'b0, 18'h0F0F0});
        cmp_rd({1'b1, 18'h30303});
        $display("back to back done");
        // Strobe high: no write
        ctrl.cyc(1'b1, 1'b0, 20'hFFFFF, 18'h11111, 18'h22222, 2'h0, 2'h0);
        idle(1);
        rd(20'hFFFFF);
        cmp_rd({1'b0, 18'h00000});
        cmp_rd({1'b1, 18'h3FFFF});
        $display("ignored command done");
        ctrl.mode(1'b0, 1'b1);
        rd(20'h00001);
        cmp_rd({1'b0, 18'h3FF45});
        cmp_rd({1'b1, 18'h2ABFF});
        cmp("spare words", 0, ctrl.rq.size());
        $display("single clock done");
        reset_n <= 1'b0;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        quiet();
        $display("reset done");
        test_done();
    end
endmodule : dsio_sram_port_tb
